// file: logic/bio_irq.sv
`timescale 1ns/100ps
`default_nettype none
module bio_irq
  import bio_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [N-1:0] event_i,
  input wire logic [N-1:0] clr_i,
  input wire logic en_wr_i,
  input wire logic [N-1:0] en_din_i,
  output logic [N-1:0] stat_o,
  output logic [N-1:0] en_o,
  output logic irq_o
);
  initial begin
    if (N < 1) $error("bio_irq needs at least one event");
  end
  // set beats clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) stat_o <= '0;
    else stat_o <= (stat_o & ~clr_i) | event_i;
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) en_o <= '0;
    else if (en_wr_i) en_o <= en_din_i;
  end
  assign irq_o = |(stat_o & en_o);
endmodule : bio_irq
`default_nettype wire

// file: logic/bio_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
module bio_pin_cell
  import bio_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic dir_i,
  input wire logic sel_i,
  input wire logic pat_i,
  input wire logic act_i,
  input wire logic level_i,
  output logic out_o,
  output logic tested_o,
  output logic true_o
);
  // output latch updated only on an action write to an output pin
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      out_o <= 1'b0;
    end else if (act_i && dir_i) begin
      case ({sel_i, pat_i})
        2'b00: out_o <= 1'b0;
        2'b01: out_o <= 1'b1;
        2'b10: out_o <= out_o;
        default: out_o <= ~out_o;
      endcase
    end
  end
  assign tested_o = ~dir_i & sel_i;
  assign true_o = (level_i == pat_i);
endmodule : bio_pin_cell
`default_nettype wire

// file: logic/bio_port.sv
`timescale 1ns/100ps
`default_nettype none
module bio_port
  import bio_pkg::*;
#(
  parameter int PINS = BIO_PINS
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] pin_i,
  output logic [PINS-1:0] pin_o,
  output logic [PINS-1:0] pin_oe_o,
  output logic [3:0] flags_o,
  output logic upper_pins_enable_o,
  output logic second_serial_select_o,
  output logic irq_o
);
  initial begin
    if (PINS != 8) $error("bio_port serves exactly eight pins");
  end

  logic [7:0] pin_direction;
  logic [7:0] action_select;
  logic [7:0] action_pattern;
  logic [1:0] io_config;
  logic action_strobe;
  logic [7:0] pin_level;
  logic [7:0] cell_out;
  logic [7:0] cell_tested;
  logic [7:0] cell_true;
  logic [7:0] pin_route;
  logic [3:0] next_flags;
  logic flags_primed;
  logic [3:0] flag_rise;
  logic [3:0] irq_stat;
  logic [3:0] irq_en;
  logic [3:0] irq_clr;
  logic irq_en_wr;

  // write channel state
  bio_wstate_e wstate;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;

  // routing to package pins
  assign pin_route = {{4{io_config[BIO_CFG_UPPER]}}, {4{io_config[BIO_CFG_LOWER]}}};
  assign upper_pins_enable_o = io_config[BIO_CFG_UPPER];
  assign second_serial_select_o = io_config[BIO_CFG_LOWER];
  // unrouted input pins read low, unrouted output pins read their latch; unrouted pins are never driven
  assign pin_level = pin_i & pin_route & ~pin_direction | cell_out & pin_direction;

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      bio_pin_cell u_cell (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .dir_i(pin_direction[g]),
        .sel_i(action_select[g]),
        .pat_i(action_pattern[g]),
        .act_i(action_strobe),
        .level_i(pin_level[g]),
        .out_o(cell_out[g]),
        .tested_o(cell_tested[g]),
        .true_o(cell_true[g])
      );
    end
  endgenerate

  assign pin_o = cell_out & pin_route;
  assign pin_oe_o = pin_direction & pin_route;

  // flags evaluated from the current pin test; empty test set gives all-true
  always_comb begin
    next_flags = '0;
    next_flags[BIO_FLAG_ALLT] = &(~cell_tested | cell_true);
    next_flags[BIO_FLAG_ALLF] = &(~cell_tested | ~cell_true);
    next_flags[BIO_FLAG_SOMET] = |(cell_tested & cell_true);
    next_flags[BIO_FLAG_SOMEF] = |(cell_tested & ~cell_true);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) flags_o <= '0;
    else flags_o <= next_flags;
  end

  // flags reset low though an empty test reads all-true: no edge on first capture
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) flags_primed <= 1'b0;
    else flags_primed <= 1'b1;
  end
  assign flag_rise = flags_primed ? (next_flags & ~flags_o) : 4'h0;

  // write path: address and data accepted in either order
  assign s_axi_awready = (wstate == BIO_W_IDLE) && !aw_held;
  assign s_axi_wready = (wstate == BIO_W_IDLE) && !w_held;
  assign wr_go = (wstate == BIO_W_IDLE) && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wa_known;
  assign wa = aw_held ? aw_addr : s_axi_awaddr;
  assign wd = w_held ? w_data : s_axi_wdata;
  assign ws = w_held ? w_strb : s_axi_wstrb;
  always_comb begin
    case (wa)
      BIO_OFS_DIRLVL, BIO_OFS_ACTION, BIO_OFS_FLAGS, BIO_OFS_CONFIG,
      BIO_OFS_IRQ_STAT, BIO_OFS_IRQ_EN, BIO_OFS_IRQ_CLR: wa_known = 1'b1;
      default: wa_known = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wstate <= BIO_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BIO_RESP_OKAY;
    end else begin
      case (wstate)
        BIO_W_IDLE: begin
          if (wr_go) begin
            wstate <= BIO_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa_known ? BIO_RESP_OKAY : BIO_RESP_SLVERR;
          end
        end
        BIO_W_RESP: begin
          if (s_axi_bready) begin
            wstate <= BIO_W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wstate <= BIO_W_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // direction in the upper byte; lower byte is read-only levels
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) pin_direction <= '0;
    else if (wr_go && wa == BIO_OFS_DIRLVL && ws[1])
      pin_direction <= wd[BIO_DIR_LSB +: 8];
  end

  // action register write also fires the per-pin action
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      action_select <= '0;
      action_pattern <= '0;
    end else if (wr_go && wa == BIO_OFS_ACTION) begin
      if (ws[0]) action_pattern <= wd[7:0];
      if (ws[1]) action_select <= wd[BIO_SEL_LSB +: 8];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) action_strobe <= 1'b0;
    else action_strobe <= wr_go && wa == BIO_OFS_ACTION && ws[1:0] != 2'h0;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) io_config <= '0;
    else if (wr_go && wa == BIO_OFS_CONFIG && ws[0]) io_config <= wd[1:0];
  end

  assign irq_en_wr = wr_go && wa == BIO_OFS_IRQ_EN && ws[0];
  assign irq_clr = (wr_go && wa == BIO_OFS_IRQ_CLR && ws[0]) ? wd[3:0] : 4'h0;

  // events are rising edges of the four test flags
  bio_irq #(.N(4)) u_irq (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(flag_rise),
    .clr_i(irq_clr),
    .en_wr_i(irq_en_wr),
    .en_din_i(wd[3:0]),
    .stat_o(irq_stat),
    .en_o(irq_en),
    .irq_o(irq_o)
  );

  // read path: one read at a time, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= BIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= BIO_RESP_OKAY;
      case (s_axi_araddr)
        BIO_OFS_DIRLVL: s_axi_rdata <= {16'h0000, pin_direction, pin_level};
        BIO_OFS_ACTION: s_axi_rdata <= {16'h0000, action_select, action_pattern};
        BIO_OFS_FLAGS: s_axi_rdata <= {28'h0000000, flags_o};
        BIO_OFS_CONFIG: s_axi_rdata <= {30'h0000000, io_config};
        BIO_OFS_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat};
        BIO_OFS_IRQ_EN: s_axi_rdata <= {28'h0000000, irq_en};
        BIO_OFS_IRQ_CLR: s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= BIO_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : bio_port
`default_nettype wire

// file: pkg/bio_pkg.sv
package bio_pkg;
  localparam int BIO_PINS = 8;
  localparam logic [7:0] BIO_OFS_DIRLVL = 8'h00;
  localparam logic [7:0] BIO_OFS_ACTION = 8'h04;
  localparam logic [7:0] BIO_OFS_FLAGS = 8'h08;
  localparam logic [7:0] BIO_OFS_CONFIG = 8'h0C;
  localparam logic [7:0] BIO_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] BIO_OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] BIO_OFS_IRQ_CLR = 8'h18;
  localparam int BIO_DIR_LSB = 8;
  localparam int BIO_SEL_LSB = 8;
  localparam int BIO_FLAG_ALLT = 0;
  localparam int BIO_FLAG_ALLF = 1;
  localparam int BIO_FLAG_SOMET = 2;
  localparam int BIO_FLAG_SOMEF = 3;
  localparam int BIO_CFG_UPPER = 0;
  localparam int BIO_CFG_LOWER = 1;
  localparam logic [1:0] BIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] BIO_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    BIO_W_IDLE = 3'b001,
    BIO_W_RESP = 3'b010,
    BIO_W_HOLD = 3'b100
  } bio_wstate_e;
endpackage : bio_pkg

// file: verif/bio_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module bio_board_model (
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] level_o
);
  // no pull-ups: a released pin shows the board's own level
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : bio_board_model
`default_nettype wire

// file: verif/bio_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bio_port_checker
  import bio_pkg::*;
#(
  parameter int PINS = BIO_PINS
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] pin_o,
  input wire logic [PINS-1:0] pin_oe_o,
  input wire logic [3:0] flags_o,
  input wire logic upper_pins_enable_o,
  input wire logic second_serial_select_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_up; !upper_pins_enable_o |-> pin_oe_o[7:4] == 4'h0; endproperty
  a_up: assert property (p_up) else $error("upper pins driven");
  property p_lo; !second_serial_select_o |-> pin_oe_o[3:0] == 4'h0; endproperty
  a_lo: assert property (p_lo) else $error("lower pins driven");
  property p_fl; !(flags_o[0] && flags_o[3]) && !(flags_o[1] && flags_o[2]); endproperty
  a_fl: assert property (p_fl) else $error("flags disagree");
  // pin_o may only move while a write response is valid or in the cycle after
  property p_pq; $changed(pin_o) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_pq: assert property (p_pq) else $error("pin moved without write");
  property p_aw; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_aw: assert property (p_aw) else $error("write taken early");
  property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("read taken early");
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rh: assert property (p_rh) else $error("read data dropped");
  property p_ux;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
      |=> s_axi_rvalid && s_axi_rresp == BIO_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_ux: assert property (p_ux) else $error("unmapped read answered");
  c_irq: cover property ($rose(irq_o));
  c_up: cover property (upper_pins_enable_o && !second_serial_select_o);
  c_lo: cover property (second_serial_select_o && !upper_pins_enable_o);
endmodule : bio_port_checker
bind bio_port bio_port_checker #(.PINS(PINS)) u_chk (.*);
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bio_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic upper_pins_enable_o, second_serial_select_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] pin_i, pin_o, pin_oe_o, dir, sel, pat, q;
  logic [3:0] flags_o;
  logic [31:0] d;
  int mismatches = 0, n_tests = 0, cycles = 0, seed = 35;
  always #12.5 mclk_i = ~mclk_i;
  bio_port i_dut (.*);
  bio_board_model u_brd (.drv_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext), .level_o(pin_i));
  function automatic logic [31:0] ex_fl(input logic [7:0] dr, sl, pt, lv);
    logic [7:0] t, f;
    t = sl & ~dr & ~(lv ^ pt);
    f = sl & ~dr & (lv ^ pt);
    return {28'h0, |f, |t, t == 8'h00, f == 8'h00};
  endfunction : ex_fl
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // rready offered with the address and held until the answer is seen
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  logic [15:0] corner [4] = '{16'h00FF, 16'hFFFF, 16'hFF00, 16'h0000};
  initial begin
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(BIO_OFS_DIRLVL);
    chk("dirlvl reset", d, 32'h0);
    rd(BIO_OFS_IRQ_STAT);
    chk("irq status reset", d, 32'h0);
    $display("reset test done");
    dir = 8'hA5;
    q = 8'h00;
    wr(BIO_OFS_CONFIG, 32'h3);
    wr(BIO_OFS_DIRLVL, {16'h0, dir, 8'h00});
    chk("write resp", {30'h0, r}, {30'h0, BIO_RESP_OKAY});
    for (int i = 0; i < 40; i++) begin
      {sel, pat} = (i < 4) ? corner[i] : 16'($random(seed));
      ext <= 8'($random(seed));
      wr(BIO_OFS_ACTION, {16'h0, sel, pat});
      q = (~sel & pat) | (sel & (q ^ pat));
      repeat (4) @(posedge mclk_i);
      chk("pin drive", {24'h0, pin_o & dir}, {24'h0, q & dir});
      chk("pin enable", {24'h0, pin_oe_o}, {24'h0, dir});
      rd(BIO_OFS_DIRLVL);
      chk("levels", d, {16'h0, dir, (q & dir) | (ext & ~dir)});
      rd(BIO_OFS_FLAGS);
      chk("flags", d, ex_fl(dir, sel, pat, ext));
      chk("flag port", {28'h0, flags_o}, ex_fl(dir, sel, pat, ext));
    end
    $display("pin action test done");
    ext <= 8'h00;
    wr(BIO_OFS_ACTION, 32'hFFFF);
    repeat (4) @(posedge mclk_i);
    wr(BIO_OFS_IRQ_CLR, 32'hF);
    wr(BIO_OFS_IRQ_EN, 32'h4);
    wr(BIO_OFS_ACTION, 32'hFF00);
    repeat (4) @(posedge mclk_i);
    rd(BIO_OFS_IRQ_STAT);
    chk("irq status", d, 32'h5);
    chk("irq on", {31'h0, irq_o}, 32'h1);
    wr(BIO_OFS_IRQ_EN, 32'h2);
    repeat (2) @(posedge mclk_i);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    wr(BIO_OFS_IRQ_EN, 32'h1);
    wr(BIO_OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    rd(BIO_OFS_IRQ_STAT);
    chk("irq status left", d, 32'h4);
    $display("interrupt test done");
    for (int c = 0; c < 4; c++) begin
      wr(BIO_OFS_CONFIG, 32'(c));
      repeat (2) @(posedge mclk_i);
      q = {{4{c[0]}}, {4{c[1]}}};
      chk("routed enables", {24'h0, pin_oe_o}, {24'h0, dir & q});
      chk("upper enable", {31'h0, upper_pins_enable_o}, {31'h0, c[0]});
      chk("serial select", {31'h0, second_serial_select_o}, {31'h0, c[1]});
      rd(BIO_OFS_CONFIG);
      chk("config", d, 32'(c));
    end
    $display("routing test done");
    wr(8'h1C, 32'hFFFF);
    chk("unmapped write", {30'h0, r}, {30'h0, BIO_RESP_SLVERR});
    rd(8'h1C);
    chk("unmapped read", {r, d[29:0]}, {BIO_RESP_SLVERR, 30'h0});
    $display("unmapped test done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
